//--- supervisor_pkg.sv
// Constants and carrier types for the supply supervisor with watchdog
package supervisor_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned RESET_DELAY_MS = 200;
  localparam int unsigned BROWNOUT_EXT_MS = 100;
  localparam int unsigned WDOG_TIMEOUT_MS = 1600;
  localparam int unsigned WDOG_MIN_MS = 1000;
  localparam int unsigned KICK_MIN_NS = 50;
  // Millisecond tick from the internal time base
  localparam int unsigned MS_TICK_CYCLES = CLK_HZ / 1000;
  // Least kick width in cycles, rounded up
  localparam int unsigned KICK_MIN_CYCLES =
    (KICK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MS_W = 32;
  localparam int unsigned CNT_W = 12;
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_DELAY = 2'b01,
    ST_RUN = 2'b11
  } sup_state_e;

  typedef struct packed {
    logic supply_ok;
    logic kick_floating;
    logic watchdog_kick_input;
    logic manual_reset_n;
  } sense_s;
endpackage

//--- supply_supervisor_watchdog_reset.sv
// Reset supervisor logic: supply hold-off, brownout, watchdog, manual reset
`timescale 1ns/1ps

// How it works
// [RULE1] Reset is held while supply is low and released 200 ms after it recovers.
// [RULE2] A supply dip during normal operation starts a reset pulse.
// [RULE3] A brownout during a pulse leaves at least 100 ms of the pulse still to run.
// [RULE4] Reset stays asserted for as long as the low supply persists.
// [RULE5] An unkicked, driven kick input asserts reset after the timeout.
// [RULE6] The watchdog count is held clear while reset is on or kick floats.
// [RULE7] The watchdog starts once reset is released and kick is driven.
// [RULE8] A kick level change lasting at least 50 ns restarts the timeout.
// [RULE9] Low supply asserts reset at once whatever the watchdog state.
// [RULE10] A floating kick input disables the watchdog entirely.
// [RULE11] Driving the manual reset input low starts a reset.
// [RULE13] Watchdog and manual resets reuse the same reset delay counter.
// [RULE14] Supply and floating detection arrive as synchronous inputs.
module supply_supervisor_watchdog_reset #(
  parameter int unsigned RESET_DELAY = supervisor_pkg::RESET_DELAY_MS,
  parameter int unsigned BROWNOUT_EXT = supervisor_pkg::BROWNOUT_EXT_MS,
  parameter int unsigned WDOG_TIMEOUT = supervisor_pkg::WDOG_TIMEOUT_MS,
  parameter int unsigned MS_CYCLES = supervisor_pkg::MS_TICK_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Sensed inputs
  input wire supervisor_pkg::sense_s sense,
  // Reset output to the processor
  output logic reset_out_n
);
  localparam logic [supervisor_pkg::CNT_W-1:0] DLY_LOAD =
    supervisor_pkg::CNT_W'(RESET_DELAY);
  localparam logic [supervisor_pkg::CNT_W-1:0] EXT_LOAD =
    supervisor_pkg::CNT_W'(BROWNOUT_EXT);
  localparam logic [supervisor_pkg::CNT_W-1:0] WD_LOAD =
    supervisor_pkg::CNT_W'(WDOG_TIMEOUT);
  localparam logic [supervisor_pkg::MS_W-1:0] MS_LAST =
    supervisor_pkg::MS_W'(MS_CYCLES - 1);
  localparam logic [3:0] KICK_LAST =
    4'(supervisor_pkg::KICK_MIN_CYCLES - 1);

  // ----------------------------------------------------------------
  // Millisecond time base
  // ----------------------------------------------------------------
  logic [supervisor_pkg::MS_W-1:0] ms_q, ms_d;
  logic tick_q, tick_d;
  always_comb begin
    tick_d = (ms_q == MS_LAST);
    ms_d = tick_d ? '0 : ms_q + 1'b1;
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ms_q <= '0;
      tick_q <= 1'b0;
    end else begin
      ms_q <= ms_d;
      tick_q <= tick_d;
    end
  end

  // ----------------------------------------------------------------
  // Kick toggle filter
  // ----------------------------------------------------------------
  // A level counts only after it has stood KICK_MIN cycles; shorter
  // glitches are dropped so noise cannot feed the watchdog.
  logic kick_lvl_q, kick_lvl_d;
  logic [3:0] kick_cnt_q, kick_cnt_d;
  logic kicked_q, kicked_d;
  always_comb begin
    kick_lvl_d = kick_lvl_q;
    kick_cnt_d = '0;
    kicked_d = 1'b0;
    // [RULE8] Qualify kick width
    if (sense.watchdog_kick_input != kick_lvl_q) begin
      kick_cnt_d = kick_cnt_q + 1'b1;
      if (kick_cnt_q >= KICK_LAST) begin
        kick_lvl_d = sense.watchdog_kick_input;
        kick_cnt_d = '0;
        kicked_d = 1'b1;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      kick_lvl_q <= 1'b0;
      kick_cnt_q <= 4'h0;
      kicked_q <= 1'b0;
    end else begin
      kick_lvl_q <= kick_lvl_d;
      kick_cnt_q <= kick_cnt_d;
      kicked_q <= kicked_d;
    end
  end

  // ----------------------------------------------------------------
  // Reset sequencer and watchdog
  // ----------------------------------------------------------------
  supervisor_pkg::sup_state_e st_q, st_d;
  logic [supervisor_pkg::CNT_W-1:0] dly_q, dly_d;
  logic [supervisor_pkg::CNT_W-1:0] wd_q, wd_d;
  logic rst_n_q, rst_n_d;
  logic wd_fire;
  logic hold_src;

  // [RULE14] Inputs already synchronous
  always_comb begin
    hold_src = !sense.supply_ok || !sense.manual_reset_n;
    wd_fire = (st_q == supervisor_pkg::ST_RUN) && tick_q &&
              !sense.kick_floating && (wd_q == supervisor_pkg::CNT_ONE);
    st_d = st_q;
    dly_d = dly_q;
    wd_d = wd_q;
    unique case (st_q)
      supervisor_pkg::ST_HOLD: begin
        // [RULE4] Hold while low supply
        // Count loaded on entry, so a brownout keeps its extension
        if (!hold_src) begin
          // [RULE1] Start release delay
          st_d = supervisor_pkg::ST_DELAY;
        end
      end
      supervisor_pkg::ST_DELAY: begin
        if (!sense.supply_ok) begin
          // [RULE3] Brownout extends pulse
          st_d = supervisor_pkg::ST_HOLD;
          dly_d = (dly_q < EXT_LOAD) ? EXT_LOAD : dly_q;
        end else if (!sense.manual_reset_n) begin
          st_d = supervisor_pkg::ST_HOLD;
          dly_d = DLY_LOAD;
        end else if (tick_q) begin
          if (dly_q <= supervisor_pkg::CNT_ONE) begin
            st_d = supervisor_pkg::ST_RUN;
            wd_d = WD_LOAD;
          end else begin
            dly_d = dly_q - 1'b1;
          end
        end
      end
      supervisor_pkg::ST_RUN: begin
        // [RULE6] Watchdog cleared when floating
        // [RULE10] Floating kick disables watchdog
        if (sense.kick_floating || kicked_q) begin
          // [RULE8] Toggle restarts timeout
          wd_d = WD_LOAD;
        end else if (tick_q) begin
          // [RULE7] Count while driven
          wd_d = wd_q - 1'b1;
        end
        // [RULE9] Low supply overrides watchdog
        // [RULE2] Dip starts reset pulse
        // [RULE11] Manual reset starts pulse
        if (hold_src) begin
          st_d = supervisor_pkg::ST_HOLD;
          dly_d = DLY_LOAD;
        end else if (wd_fire) begin
          // [RULE5] Timeout asserts reset
          // [RULE13] Reuse reset delay counter
          st_d = supervisor_pkg::ST_DELAY;
          dly_d = DLY_LOAD;
        end
      end
      default: st_d = supervisor_pkg::ST_HOLD;
    endcase
    if (st_d != supervisor_pkg::ST_RUN) begin
      // [RULE6] Watchdog cleared during reset
      wd_d = WD_LOAD;
    end
    rst_n_d = (st_d == supervisor_pkg::ST_RUN);
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_q <= supervisor_pkg::ST_HOLD;
      dly_q <= DLY_LOAD;
      wd_q <= WD_LOAD;
      rst_n_q <= 1'b0;
    end else begin
      st_q <= st_d;
      dly_q <= dly_d;
      wd_q <= wd_d;
      rst_n_q <= rst_n_d;
    end
  end
  assign reset_out_n = rst_n_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_low;
    !sense.supply_ok;
  endsequence
  sequence s_low_out;
    ##1 !reset_out_n;
  endsequence

  property p_low_holds;
    @(posedge ref_clk) disable iff (reset) s_low |-> s_low_out;
  endproperty
  a_low_holds: assert property (p_low_holds) // [RULE4]
    else $error("reset released during low supply");

  property p_mr_asserts;
    @(posedge ref_clk) disable iff (reset)
      !sense.manual_reset_n |=> !reset_out_n;
  endproperty
  a_mr_asserts: assert property (p_mr_asserts) // [RULE11]
    else $error("manual reset did not assert reset");

  property p_no_early_release;
    @(posedge ref_clk) disable iff (reset)
      $rose(reset_out_n) |-> $past(st_q) == supervisor_pkg::ST_DELAY;
  endproperty
  a_no_early_release: assert property (p_no_early_release) // [RULE1]
    else $error("reset released without delay");

  property p_wd_cleared;
    @(posedge ref_clk) disable iff (reset)
      !reset_out_n |-> wd_q == WD_LOAD;
  endproperty
  a_wd_cleared: assert property (p_wd_cleared) // [RULE6]
    else $error("watchdog counted during reset");

  property p_float_hold;
    @(posedge ref_clk) disable iff (reset)
      sense.kick_floating && st_q == supervisor_pkg::ST_RUN |=>
      wd_q == WD_LOAD;
  endproperty
  a_float_hold: assert property (p_float_hold) // [RULE10]
    else $error("watchdog ran with floating kick");

  property p_wd_fires;
    @(posedge ref_clk) disable iff (reset)
      wd_fire && !hold_src |=> !reset_out_n && dly_q == DLY_LOAD;
  endproperty
  a_wd_fires: assert property (p_wd_fires) // [RULE5]
    else $error("watchdog timeout did not reset");

  property p_brownout_ext;
    @(posedge ref_clk) disable iff (reset)
      st_q == supervisor_pkg::ST_DELAY && !sense.supply_ok |=>
      dly_q >= EXT_LOAD;
  endproperty
  a_brownout_ext: assert property (p_brownout_ext) // [RULE3]
    else $error("brownout did not extend pulse");

  property p_ext_kept;
    @(posedge ref_clk) disable iff (reset)
      st_q == supervisor_pkg::ST_HOLD |=> $stable(dly_q);
  endproperty
  a_ext_kept: assert property (p_ext_kept) // [RULE3]
    else $error("delay count changed while held");

  property p_kick_restart;
    @(posedge ref_clk) disable iff (reset)
      kicked_q && st_q == supervisor_pkg::ST_RUN && !hold_src |=>
      wd_q == WD_LOAD;
  endproperty
  a_kick_restart: assert property (p_kick_restart) // [RULE8]
    else $error("kick did not restart timeout");

  property p_dip_pulse;
    @(posedge ref_clk) disable iff (reset)
      reset_out_n && !sense.supply_ok |=> !reset_out_n;
  endproperty
  a_dip_pulse: assert property (p_dip_pulse) // [RULE2]
    else $error("supply dip missed");

  property p_start_count;
    @(posedge ref_clk) disable iff (reset)
      reset_out_n && $past(reset_out_n) && !sense.kick_floating &&
      !kicked_q && tick_q && !hold_src && !wd_fire |=>
      wd_q == $past(wd_q) - 1'b1;
  endproperty
  a_start_count: assert property (p_start_count) // [RULE7]
    else $error("watchdog did not count");
endmodule

//--- proc_model.sv
// Processor-side model that kicks the watchdog input on command
`timescale 1ns/1ps
module proc_model (
  // Clock
  input wire logic ref_clk,
  // Control from the bench
  input wire logic [1:0] mode,
  input wire logic [7:0] period,
  // Device side
  input wire logic reset_out_n,
  output logic kick
);
  logic [7:0] cnt_q = 8'h00;

  initial begin
    kick = 1'b0;
  end

  // ----------------------------------------------------------------
  // Kick generator
  // ----------------------------------------------------------------
  // Kick pulse width
  // Mode 1 holds each level for period + 1 cycles while reset is released; the bench sets period to five or more.
  // Mode 2 makes 3-cycle glitches that must not count as kicks.
  // No loopback
  // Reset out is not looped to manual reset, since a held manual
  // reset would lock the system in reset.
  always @(posedge ref_clk) begin
    cnt_q <= cnt_q + 8'h01;
    if (mode == 2'h1) begin
      if (reset_out_n && cnt_q >= period) begin
        kick <= ~kick;
        cnt_q <= 8'h00;
      end
    end else if (mode == 2'h2) begin
      kick <= (cnt_q[5:0] < 6'h03);
    end else begin
      kick <= 1'b0;
    end
  end
endmodule

//--- tb.sv
// Self-checking bench for the supply supervisor with watchdog
`timescale 1ns/1ps
module tb;
  localparam int MS = 10;
  localparam int RD = 20;
  localparam int BE = 10;
  localparam int WD = 40;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic sup_ok = 1'b0;
  logic floating = 1'b0;
  logic mr_n = 1'b1;
  logic kick;
  logic [1:0] mode = 2'h0;
  logic [7:0] period = 8'h10;
  logic reset_out_n;
  supervisor_pkg::sense_s sense;
  int error_cnt = 0;
  int n_compared = 0;
  int n;
  int t;

  assign sense = {sup_ok, floating, kick, mr_n};
  always #5 ref_clk = ~ref_clk;

  supply_supervisor_watchdog_reset #(.RESET_DELAY(RD), .BROWNOUT_EXT(BE),
    .WDOG_TIMEOUT(WD), .MS_CYCLES(MS)) i_dut (.ref_clk(ref_clk),
    .reset(reset), .sense(sense), .reset_out_n(reset_out_n));
  proc_model i_proc (.ref_clk(ref_clk), .mode(mode), .period(period),
    .reset_out_n(reset_out_n), .kick(kick));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Release may land up to one tick late, plus register stages
  function automatic int rel_hi(input int ms);
    return (ms + 1) * MS + 4;
  endfunction

  // First tick may follow a change after one cycle, so one tick is short
  function automatic int rel_lo(input int ms);
    return (ms - 1) * MS + 2;
  endfunction

  task automatic chk(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic wait_lvl(input logic v, input int lim, output int cnt);
    cnt = 0;
    while (reset_out_n !== v && cnt < lim) begin
      @(posedge ref_clk);
      #1;
      cnt++;
    end
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h417a88b8));
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    t = 100 + $urandom % 100;
    @(posedge ref_clk);
    #1;
    wait_lvl(1'b1, t, n);
    chk(n, t, t);
    @(posedge ref_clk);
    sup_ok <= 1'b1;
    #1;
    wait_lvl(1'b1, rel_hi(RD) + 1, n);
    chk(n, rel_lo(RD), rel_hi(RD));
    @(posedge ref_clk);
    period <= 8'(5 + $urandom % 120);
    mode <= 2'h1;
    #1;
    wait_lvl(1'b0, 3 * WD * MS, n);
    chk(n, 3 * WD * MS, 3 * WD * MS);
    // Glitches only: the last real kick may be a full period back
    @(posedge ref_clk);
    mode <= 2'h2;
    #1;
    wait_lvl(1'b0, rel_hi(WD) + 70, n);
    chk(n, (WD - 1) * MS - 125, rel_hi(WD));
    wait_lvl(1'b1, rel_hi(RD) + 1, n);
    chk(n, RD * MS - 2, rel_hi(RD));
    @(posedge ref_clk);
    floating <= 1'b1;
    mode <= 2'h0;
    #1;
    wait_lvl(1'b0, 2 * WD * MS, n);
    chk(n, 2 * WD * MS, 2 * WD * MS);
    @(posedge ref_clk);
    floating <= 1'b0;
    mode <= 2'h1;
    t = 1 + $urandom % 40;
    @(posedge ref_clk);
    sup_ok <= 1'b0;
    #1;
    wait_lvl(1'b0, 2, n);
    chk(n, 1, 1);
    repeat (t) @(posedge ref_clk);
    sup_ok <= 1'b1;
    // Late dip leaves little delay, so the extension must win
    repeat ((RD - 3) * MS) @(posedge ref_clk);
    sup_ok <= 1'b0;
    repeat (2) @(posedge ref_clk);
    sup_ok <= 1'b1;
    #1;
    wait_lvl(1'b1, rel_hi(BE) + 1, n);
    chk(n, rel_lo(BE), rel_hi(BE));
    t = 1 + $urandom % 20;
    @(posedge ref_clk);
    mr_n <= 1'b0;
    #1;
    wait_lvl(1'b0, 2, n);
    chk(n, 1, 1);
    repeat (t) @(posedge ref_clk);
    mr_n <= 1'b1;
    #1;
    wait_lvl(1'b1, rel_hi(RD) + 1, n);
    chk(n, rel_lo(RD), rel_hi(RD));
    close_out();
  end

  initial begin
    #100000;
    error_cnt++;
    close_out();
  end
endmodule
